// File: pkg/ufc_pkg.sv
// constants and types of the uart flow and feature configuration block
`default_nettype none
package ufc_pkg;
    // register offsets on the host register port
    localparam logic [2:0] UFC_ADDR_FIFO_EFR = 3'h2;
    localparam logic [2:0] UFC_ADDR_LINE     = 3'h3;
    // reset values
    localparam logic [7:0] UFC_EFR_RESET     = 8'h00;
    localparam logic [7:0] UFC_LCR_RESET     = 8'h1d;
    localparam logic [7:0] UFC_FCR_RESET     = 8'h00;
    // line control value that opens the enhanced feature register
    localparam logic [7:0] UFC_LCR_EFR_KEY   = 8'hbf;
    // enhanced_feature_control fields
    localparam int UFC_EFR_AUTO_CTS  = 7;
    localparam int UFC_EFR_AUTO_RTS  = 6;
    localparam int UFC_EFR_SPECIAL   = 5;
    localparam int UFC_EFR_ENH       = 4;
    localparam int UFC_EFR_TXSW_LSB  = 2;
    localparam int UFC_EFR_RXSW_LSB  = 0;
    // fifo_control fields
    localparam int UFC_FCR_ENABLE    = 0;
    localparam int UFC_FCR_RX_RESET  = 1;
    localparam int UFC_FCR_TX_RESET  = 2;
    localparam int UFC_FCR_TXTRIG_LSB = 4;
    localparam int UFC_FCR_RXTRIG_LSB = 6;
    // line_format_control divisor-access bit
    localparam int UFC_LCR_DLAB      = 7;
    // special_function_select bit that hides the enhanced register
    localparam int UFC_SFR_ALT       = 2;
    // interrupt_identification bit owned here
    localparam int UFC_IIR_SPECIAL   = 4;
    // software flow control pair selections
    localparam logic [1:0] UFC_SW_NONE   = 2'b00;
    localparam logic [1:0] UFC_SW_FIRST  = 2'b10;
    localparam logic [1:0] UFC_SW_SECOND = 2'b01;
    localparam logic [1:0] UFC_SW_BOTH   = 2'b11;
    // fifo depths and levels, in characters
    localparam int          UFC_LVL_W        = 7;
    localparam int          UFC_FIFO_DEPTH   = 64;
    localparam logic [6:0]  UFC_SINGLE_DEPTH = 7'h01;
    localparam logic [6:0]  UFC_RX_TRIG_0    = 7'h08;
    localparam logic [6:0]  UFC_RX_TRIG_1    = 7'h10;
    localparam logic [6:0]  UFC_RX_TRIG_2    = 7'h38;
    localparam logic [6:0]  UFC_RX_TRIG_3    = 7'h3c;
    localparam logic [6:0]  UFC_TX_TRIG_0    = 7'h08;
    localparam logic [6:0]  UFC_TX_TRIG_1    = 7'h10;
    localparam logic [6:0]  UFC_TX_TRIG_2    = 7'h20;
    localparam logic [6:0]  UFC_TX_TRIG_3    = 7'h38;

    typedef struct packed {
        logic [7:0] resume_char_first;
        logic [7:0] resume_char_second;
        logic [7:0] stop_char_first;
        logic [7:0] stop_char_second;
    } ufc_flow_chars_t;
endpackage
`default_nettype wire

// File: design/ufc_top.sv
// flow control and enhanced feature configuration of the uart bridge
// Summary of operation
// - fifo off: one character, trigger one, fields frozen
// - fifo on: both fifos hold sixty-four characters
// - transmit trigger written only with enhanced enable
// - enhanced register at 02h, key 0xbf, select clear
// - bit 7 enables cts transmit gating
// - bit 6 enables automatic rts driving
// - bit 5: second stop character flagged, stored unless taken as a stop
// - bit 4 gates enhanced writes and sleep
// - bits 3:2 choose transmitted resume/stop pairs
// - bits 1:0 choose received comparison pair
// - 1011/0111: either character of each kind accepted
// - 1111/0011: only first-then-second sequences recognised
// - line control at 03h resets to 0x1d
// - special flag cleared by resume if also a stop, else by read
// - offset 02h is fifo control when dlab clear
`default_nettype none
module ufc_top
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = UFC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            resetn_i,
    // host register port
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [2:0]      reg_addr_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic      [7:0]      reg_rdata_o,
    // neighbouring register state
    input  wire logic [7:0]      special_function_select_i,
    input  wire ufc_flow_chars_t flow_chars_i,
    input  wire logic            mcr_rts_low_i,
    // receiver side
    input  wire logic            rx_valid_i,
    input  wire logic [7:0]      rx_char_i,
    input  wire logic            rx_above_halt_i,
    output logic                 rx_store_o,
    output logic      [7:0]      rx_char_o,
    output logic                 resume_det_o,
    output logic                 stop_det_o,
    output logic                 special_int_o,
    output logic                 stop_int_o,
    // modem pins
    input  wire logic            cts_n_i,
    output logic                 rts_n_o,
    output logic                 tx_cts_hold_o,
    // configuration to transmitter, fifos and other registers
    output logic                 fifo_enable_o,
    output logic      [6:0]      fifo_depth_o,
    output logic      [6:0]      rx_trig_level_o,
    output logic      [6:0]      tx_trig_level_o,
    output logic                 rx_fifo_reset_o,
    output logic                 tx_fifo_reset_o,
    output logic                 enh_write_en_o,
    output logic                 sleep_allow_o,
    output logic      [1:0]      tx_sw_select_o,
    output logic      [7:0]      line_format_o
);

    function automatic logic [6:0] rx_trig(input logic [1:0] code);
        case (code)
            2'b00:   rx_trig = UFC_RX_TRIG_0;
            2'b01:   rx_trig = UFC_RX_TRIG_1;
            2'b10:   rx_trig = UFC_RX_TRIG_2;
            default: rx_trig = UFC_RX_TRIG_3;
        endcase
    endfunction

    function automatic logic [6:0] tx_trig(input logic [1:0] code);
        case (code)
            2'b00:   tx_trig = UFC_TX_TRIG_0;
            2'b01:   tx_trig = UFC_TX_TRIG_1;
            2'b10:   tx_trig = UFC_TX_TRIG_2;
            default: tx_trig = UFC_TX_TRIG_3;
        endcase
    endfunction

    localparam logic [6:0] DEPTH = 7'(FIFO_DEPTH);

    // register group
    logic [7:0] efr_q, efr_d;
    logic [7:0] lcr_q, lcr_d;
    logic       fen_q, fen_d;
    logic [1:0] rxtc_q, rxtc_d;
    logic [1:0] txtc_q, txtc_d;
    logic       rxrst_q, rxrst_d;
    logic       txrst_q, txrst_d;
    logic [7:0] rdata_q, rdata_d;
    logic       iir_rd;
    logic       efr_sel;
    logic       fcr_sel;
    logic       spec_q, spec_d;

    always_comb begin
        efr_d   = efr_q;
        lcr_d   = lcr_q;
        fen_d   = fen_q;
        rxtc_d  = rxtc_q;
        txtc_d  = txtc_q;
        rxrst_d = 1'b0;
        txrst_d = 1'b0;
        rdata_d = rdata_q;
        iir_rd  = 1'b0;
        efr_sel = (lcr_q == UFC_LCR_EFR_KEY) &&
                  !special_function_select_i[UFC_SFR_ALT];
        fcr_sel = !lcr_q[UFC_LCR_DLAB];
        if (reg_wr_i) begin
            if (reg_addr_i == UFC_ADDR_FIFO_EFR && efr_sel) begin
                efr_d = reg_wdata_i;
            end else if (reg_addr_i == UFC_ADDR_FIFO_EFR && fcr_sel) begin
                fen_d = reg_wdata_i[UFC_FCR_ENABLE];
                if (reg_wdata_i[UFC_FCR_ENABLE]) begin
                    rxtc_d  = reg_wdata_i[UFC_FCR_RXTRIG_LSB +: 2];
                    rxrst_d = reg_wdata_i[UFC_FCR_RX_RESET];
                    txrst_d = reg_wdata_i[UFC_FCR_TX_RESET];
                    if (efr_q[UFC_EFR_ENH]) begin
                        txtc_d = reg_wdata_i[UFC_FCR_TXTRIG_LSB +: 2];
                    end
                end
            end else if (reg_addr_i == UFC_ADDR_LINE) begin
                lcr_d = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            rdata_d = 8'h00;
            if (reg_addr_i == UFC_ADDR_FIFO_EFR && efr_sel) begin
                rdata_d = efr_q;
            end else if (reg_addr_i == UFC_ADDR_FIFO_EFR && fcr_sel) begin
                rdata_d[UFC_IIR_SPECIAL] = spec_q;
                iir_rd = 1'b1;
            end else if (reg_addr_i == UFC_ADDR_LINE) begin
                rdata_d = lcr_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            efr_q   <= UFC_EFR_RESET;
            lcr_q   <= UFC_LCR_RESET;
            fen_q   <= UFC_FCR_RESET[UFC_FCR_ENABLE];
            rxtc_q  <= UFC_FCR_RESET[UFC_FCR_RXTRIG_LSB +: 2];
            txtc_q  <= UFC_FCR_RESET[UFC_FCR_TXTRIG_LSB +: 2];
            rxrst_q <= 1'b0;
            txrst_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            efr_q   <= efr_d;
            lcr_q   <= lcr_d;
            fen_q   <= fen_d;
            rxtc_q  <= rxtc_d;
            txtc_q  <= txtc_d;
            rxrst_q <= rxrst_d;
            txrst_q <= txrst_d;
            rdata_q <= rdata_d;
        end
    end

    // configuration outputs, registered from the next register values
    logic [6:0] depth_q, depth_d;
    logic [6:0] rxlvl_q, rxlvl_d;
    logic [6:0] txlvl_q, txlvl_d;

    always_comb begin
        depth_d = fen_d ? DEPTH : UFC_SINGLE_DEPTH;
        rxlvl_d = fen_d ? rx_trig(rxtc_d) : UFC_SINGLE_DEPTH;
        txlvl_d = fen_d ? tx_trig(txtc_d) : UFC_SINGLE_DEPTH;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            depth_q <= UFC_SINGLE_DEPTH;
            rxlvl_q <= UFC_SINGLE_DEPTH;
            txlvl_q <= UFC_SINGLE_DEPTH;
        end else begin
            depth_q <= depth_d;
            rxlvl_q <= rxlvl_d;
            txlvl_q <= txlvl_d;
        end
    end

    // hardware flow control
    logic cts_s1_q, cts_s2_q;
    logic hold_q, hold_d;
    logic rts_n_q, rts_n_d;

    always_comb begin
        hold_d  = efr_q[UFC_EFR_AUTO_CTS] && cts_s2_q;
        rts_n_d = efr_q[UFC_EFR_AUTO_RTS] ? rx_above_halt_i
                                          : !mcr_rts_low_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
            hold_q   <= 1'b0;
            rts_n_q  <= 1'b1;
        end else begin
            cts_s1_q <= cts_n_i;
            cts_s2_q <= cts_s1_q;
            hold_q   <= hold_d;
            rts_n_q  <= rts_n_d;
        end
    end

    // receive comparison and special character detection
    logic       pend_on_q, pend_on_d;
    logic       pend_off_q, pend_off_d;
    logic       store_q, store_d;
    logic [7:0] char_q, char_d;
    logic       res_q, res_d;
    logic       stp_q, stp_d;
    logic       cause_stop_q, cause_stop_d;
    logic       stop_int_q, stop_int_d;
    logic       seq, any, use1, use2;
    logic       on1, on2, off1, off2;
    logic       resume, stop, consumed, special;
    logic [1:0] rxm, txm;

    always_comb begin
        rxm  = efr_q[UFC_EFR_RXSW_LSB +: 2];
        txm  = efr_q[UFC_EFR_TXSW_LSB +: 2];
        seq  = (rxm == UFC_SW_BOTH) &&
               (txm == UFC_SW_BOTH || txm == UFC_SW_NONE);
        any  = (rxm == UFC_SW_BOTH) && !seq;
        use1 = (rxm == UFC_SW_FIRST) || any;
        use2 = (rxm == UFC_SW_SECOND) || any;
        on1  = rx_char_i == flow_chars_i.resume_char_first;
        on2  = rx_char_i == flow_chars_i.resume_char_second;
        off1 = rx_char_i == flow_chars_i.stop_char_first;
        off2 = rx_char_i == flow_chars_i.stop_char_second;
        pend_on_d  = pend_on_q;
        pend_off_d = pend_off_q;
        if (seq) begin
            resume   = rx_valid_i && pend_on_q && on2;
            stop     = rx_valid_i && pend_off_q && off2;
            consumed = on1 || off1 || resume || stop;
            if (rx_valid_i) begin
                pend_on_d  = on1;
                pend_off_d = off1;
            end
        end else begin
            resume   = rx_valid_i && ((use1 && on1) || (use2 && on2));
            stop     = rx_valid_i && ((use1 && off1) || (use2 && off2));
            consumed = resume || stop;
            pend_on_d  = 1'b0;
            pend_off_d = 1'b0;
        end
        special = rx_valid_i && efr_q[UFC_EFR_SPECIAL] && off2;
        store_d = rx_valid_i && !consumed;
        char_d  = rx_valid_i ? rx_char_i : char_q;
        res_d   = resume;
        stp_d   = stop;
        // clears first, so that a same-cycle set wins
        spec_d       = spec_q;
        cause_stop_d = cause_stop_q;
        if (spec_q && cause_stop_q && resume) begin
            spec_d = 1'b0;
        end
        if (spec_q && !cause_stop_q && iir_rd) begin
            spec_d = 1'b0;
        end
        if (special) begin
            spec_d       = 1'b1;
            cause_stop_d = stop && off2;
        end
        stop_int_d = stop_int_q;
        if (resume) begin
            stop_int_d = 1'b0;
        end
        if (stop) begin
            stop_int_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pend_on_q    <= 1'b0;
            pend_off_q   <= 1'b0;
            store_q      <= 1'b0;
            char_q       <= 8'h00;
            res_q        <= 1'b0;
            stp_q        <= 1'b0;
            spec_q       <= 1'b0;
            cause_stop_q <= 1'b0;
            stop_int_q   <= 1'b0;
        end else begin
            pend_on_q    <= pend_on_d;
            pend_off_q   <= pend_off_d;
            store_q      <= store_d;
            char_q       <= char_d;
            res_q        <= res_d;
            stp_q        <= stp_d;
            spec_q       <= spec_d;
            cause_stop_q <= cause_stop_d;
            stop_int_q   <= stop_int_d;
        end
    end

    assign reg_rdata_o     = rdata_q;
    assign rx_store_o      = store_q;
    assign rx_char_o       = char_q;
    assign resume_det_o    = res_q;
    assign stop_det_o      = stp_q;
    assign special_int_o   = spec_q;
    assign stop_int_o      = stop_int_q;
    assign rts_n_o         = rts_n_q;
    assign tx_cts_hold_o   = hold_q;
    assign fifo_enable_o   = fen_q;
    assign fifo_depth_o    = depth_q;
    assign rx_trig_level_o = rxlvl_q;
    assign tx_trig_level_o = txlvl_q;
    assign rx_fifo_reset_o = rxrst_q;
    assign tx_fifo_reset_o = txrst_q;
    assign enh_write_en_o  = efr_q[UFC_EFR_ENH];
    assign sleep_allow_o   = efr_q[UFC_EFR_ENH];
    assign tx_sw_select_o  = efr_q[UFC_EFR_TXSW_LSB +: 2];
    assign line_format_o   = lcr_q;

endmodule
`default_nettype wire

// File: testbench/ufc_peer_model.sv
// remote uart peer: received characters, cts pin and receive level
`default_nettype none
module ufc_peer_model (
    // clock
    input  wire logic       clk_i,
    // towards the receiver and modem pins
    output logic            rx_valid_o,
    output logic      [7:0] rx_char_o,
    output logic            cts_n_o,
    output logic            above_halt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid_o   = 1'b0;
        rx_char_o    = 8'h00;
        cts_n_o      = 1'b0;
        above_halt_o = 1'b0;
    end
    // back-to-back calls give strobes on consecutive cycles
    task automatic send(input logic [7:0] c);
        @(negedge clk_i);
        rx_valid_o = 1'b1;
        rx_char_o  = c;
    endtask
    // released data shows the inverse of the last character
    task automatic rest();
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_char_o  = ~rx_char_o;
    endtask
    task automatic line(input logic cts, input logic halt);
        @(negedge clk_i);
        cts_n_o      = cts;
        above_halt_o = halt;
    endtask
endmodule
`default_nettype wire

// File: testbench/ufc_chk_sva.sv
// assertions on the ports of the flow and feature configuration block
`default_nettype none
module ufc_chk
    import ufc_pkg::*;
#(
    parameter int FIFO_DEPTH = UFC_FIFO_DEPTH
) (
    input wire logic       ref_clk_i,
    input wire logic       resetn_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] special_function_select_i,
    input wire logic       cts_n_i,
    input wire logic       rx_store_o,
    input wire logic       stop_det_o,
    input wire logic       resume_det_o,
    input wire logic       stop_int_o,
    input wire logic       tx_cts_hold_o,
    input wire logic       fifo_enable_o,
    input wire logic [6:0] fifo_depth_o,
    input wire logic [6:0] rx_trig_level_o,
    input wire logic       enh_write_en_o,
    input wire logic       sleep_allow_o,
    input wire logic [7:0] line_format_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_efr_open;
        reg_addr_i == UFC_ADDR_FIFO_EFR && line_format_o == UFC_LCR_EFR_KEY
            && !special_function_select_i[UFC_SFR_ALT];
    endsequence
    sequence s_efr_wr_rd;
        (reg_wr_i and s_efr_open) ##1 (reg_rd_i and s_efr_open);
    endsequence
    property p_line_reset;
        disable iff (1'b0) !resetn_i |=> line_format_o == UFC_LCR_RESET;
    endproperty
    a_line_reset: assert property (p_line_reset)
        else $error("line control not at reset value");
    property p_line_write;
        reg_wr_i && reg_addr_i == UFC_ADDR_LINE
            |=> line_format_o == $past(reg_wdata_i);
    endproperty
    a_line_write: assert property (p_line_write)
        else $error("line control write lost");
    property p_efr_access;
        s_efr_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_efr_access: assert property (p_efr_access)
        else $error("enhanced register readback wrong");
    property p_fifo_off;
        !fifo_enable_o |-> fifo_depth_o == UFC_SINGLE_DEPTH
            && rx_trig_level_o == UFC_SINGLE_DEPTH;
    endproperty
    a_fifo_off: assert property (p_fifo_off)
        else $error("single character mode levels wrong");
    property p_fifo_on;
        fifo_enable_o |-> fifo_depth_o == 7'(FIFO_DEPTH);
    endproperty
    a_fifo_on: assert property (p_fifo_on)
        else $error("fifo depth wrong");
    property p_cts;
        tx_cts_hold_o |-> $past(cts_n_i, 3);
    endproperty
    a_cts: assert property (p_cts)
        else $error("transmit held without inactive cts");
    property p_stop;
        stop_det_o |-> !rx_store_o && stop_int_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop character stored or not flagged");
    property p_stop_clr;
        $fell(stop_int_o) |-> resume_det_o;
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("stop interrupt cleared without resume");
    property p_sleep;
        sleep_allow_o == enh_write_en_o;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep permission differs from enhanced enable");
endmodule
bind ufc_top ufc_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .ref_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .special_function_select_i, .cts_n_i, .rx_store_o,
    .stop_det_o, .resume_det_o, .stop_int_o, .tx_cts_hold_o, .fifo_enable_o,
    .fifo_depth_o, .rx_trig_level_o, .enh_write_en_o, .sleep_allow_o,
    .line_format_o);
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench of the flow and feature configuration block
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench
    import ufc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] RS1 = 8'h11, RS2 = 8'h12, ST1 = 8'h13, ST2 = 8'h14;
    logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, mcr_rts_low_i, rx_valid_i;
    logic rx_above_halt_i, cts_n_i, rx_store_o, resume_det_o, stop_det_o;
    logic special_int_o, stop_int_o, rts_n_o, tx_cts_hold_o, fifo_enable_o;
    logic rx_fifo_reset_o, tx_fifo_reset_o, enh_write_en_o, sleep_allow_o;
    logic [2:0] reg_addr_i;
    logic [7:0] reg_wdata_i, special_function_select_i, reg_rdata_o;
    logic [7:0] rx_char_i, rx_char_o, line_format_o;
    logic [6:0] fifo_depth_o, rx_trig_level_o, tx_trig_level_o;
    logic [1:0] tx_sw_select_o;
    ufc_flow_chars_t flow_chars_i;
    int n_errors = 0, n_checks = 0, n_cycles = 0;
    ufc_top i_dut (.ref_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .special_function_select_i, .flow_chars_i,
        .mcr_rts_low_i, .rx_valid_i, .rx_char_i, .rx_above_halt_i,
        .rx_store_o, .rx_char_o, .resume_det_o, .stop_det_o, .special_int_o,
        .stop_int_o, .cts_n_i, .rts_n_o, .tx_cts_hold_o, .fifo_enable_o,
        .fifo_depth_o, .rx_trig_level_o, .tx_trig_level_o, .rx_fifo_reset_o,
        .tx_fifo_reset_o, .enh_write_en_o, .sleep_allow_o, .tx_sw_select_o,
        .line_format_o);
    ufc_peer_model i_peer (.clk_i(ref_clk_i), .rx_valid_o(rx_valid_i),
        .rx_char_o(rx_char_i), .cts_n_o(cts_n_i),
        .above_halt_o(rx_above_halt_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        n_cycles++;
        if (n_cycles == 4000) begin
            n_errors++;
            give_verdict();
        end
    end
    // request driven at a negedge and held until the next call replaces it
    task automatic bus(input logic w, r, input logic [2:0] a,
                       input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_wr_i    = w;
        reg_rd_i    = r;
        reg_addr_i  = a;
        reg_wdata_i = d;
    endtask
    // leaves line control at 03 so offset 2 is fifo control again
    task automatic set_efr(input logic [7:0] v);
        bus(1'b1, 1'b0, 3'h3, 8'hbf);
        bus(1'b1, 1'b0, 3'h2, v);
        bus(1'b1, 1'b0, 3'h3, 8'h03);
        bus(1'b0, 1'b0, 3'h3, 8'h00);
    endtask
    task automatic rd(input logic [2:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
    endtask
    task automatic rx(input logic [7:0] c);
        i_peer.send(c);
        i_peer.rest();
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    initial begin
        {resetn_i, reg_wr_i, reg_rd_i, mcr_rts_low_i} = 4'h0;
        reg_addr_i = 3'h0;
        reg_wdata_i = 8'h00;
        special_function_select_i = 8'h00;
        flow_chars_i = {RS1, RS2, ST1, ST2};
        repeat (6) @(negedge ref_clk_i);
        `CHK("line reset", UFC_LCR_RESET, line_format_o)
        resetn_i = 1'b1;
        rd(3'h3);
        `CHK("line read", 8'h1d, reg_rdata_o)
        rd(3'h5);
        `CHK("unmapped", 8'h00, reg_rdata_o)
        bus(1'b1, 1'b0, 3'h3, 8'hbf);
        rd(3'h2);
        `CHK("enhanced reset", 8'h00, reg_rdata_o)
        special_function_select_i = 8'h04;
        bus(1'b1, 1'b0, 3'h2, 8'hff);
        bus(1'b1, 1'b0, 3'h3, 8'h80);
        special_function_select_i = 8'h00;
        bus(1'b1, 1'b0, 3'h2, 8'hff);
        bus(1'b1, 1'b0, 3'h3, 8'hbf);
        rd(3'h2);
        `CHK("enhanced gated", 8'h00, reg_rdata_o)
        bus(1'b1, 1'b0, 3'h2, 8'h0c);
        rd(3'h2);
        `CHK("enhanced write", 8'h0c, reg_rdata_o)
        done("access");
        set_efr(8'h00);
        bus(1'b1, 1'b0, 3'h2, 8'hf1);
        bus(1'b0, 1'b0, 3'h2, 8'h00);
        `CHK("depth", 7'h40, fifo_depth_o)
        `CHK("rx trig", UFC_RX_TRIG_3, rx_trig_level_o)
        `CHK("tx trig kept", UFC_TX_TRIG_0, tx_trig_level_o)
        set_efr(8'h10);
        bus(1'b1, 1'b0, 3'h2, 8'hb7);
        bus(1'b0, 1'b0, 3'h2, 8'h00);
        `CHK("tx trig", UFC_TX_TRIG_3, tx_trig_level_o)
        `CHK("rx reset", 1'b1, rx_fifo_reset_o)
        `CHK("tx reset", 1'b1, tx_fifo_reset_o)
        `CHK("enable", 1'b1, fifo_enable_o)
        bus(1'b1, 1'b0, 3'h2, 8'h06);
        bus(1'b0, 1'b0, 3'h2, 8'h00);
        `CHK("no reset", 1'b0, rx_fifo_reset_o)
        `CHK("disable", 1'b0, fifo_enable_o)
        `CHK("single", 7'h01, fifo_depth_o)
        `CHK("single trig", 7'h01, tx_trig_level_o)
        done("fifo");
        for (int k = 0; k < 4; k++) begin
            set_efr({4'h1, k[1:0], 2'b00});
            `CHK("tx select", k[1:0], tx_sw_select_o)
            `CHK("sleep", 1'b1, sleep_allow_o)
        end
        set_efr(8'h80);
        `CHK("enhanced off", 1'b0, enh_write_en_o)
        i_peer.line(1'b1, 1'b0);
        repeat (4) @(negedge ref_clk_i);
        `CHK("cts hold", 1'b1, tx_cts_hold_o)
        set_efr(8'h00);
        `CHK("cts off", 1'b0, tx_cts_hold_o)
        mcr_rts_low_i = 1'b1;
        set_efr(8'h40);
        i_peer.line(1'b0, 1'b1);
        repeat (2) @(negedge ref_clk_i);
        `CHK("auto rts", 1'b1, rts_n_o)
        set_efr(8'h00);
        `CHK("manual rts", 1'b0, rts_n_o)
        done("modem");
        set_efr(8'h21);
        rx(ST2);
        `CHK("stop det", 1'b1, stop_det_o)
        `CHK("special", 1'b1, special_int_o)
        `CHK("stop int", 1'b1, stop_int_o)
        `CHK("not stored", 1'b0, rx_store_o)
        rd(3'h2);
        `CHK("special kept", 1'b1, special_int_o)
        rx(RS2);
        `CHK("resume", 1'b1, resume_det_o)
        `CHK("special clr", 1'b0, special_int_o)
        `CHK("stop int clr", 1'b0, stop_int_o)
        set_efr(8'h20);
        rx(ST2);
        `CHK("stored", 1'b1, rx_store_o)
        `CHK("char", ST2, rx_char_o)
        rd(3'h2);
        `CHK("iid", 8'h10, reg_rdata_o)
        `CHK("read clr", 1'b0, special_int_o)
        set_efr(8'h02);
        rx(ST1);
        `CHK("first stop", 1'b1, stop_det_o)
        rx(ST2);
        `CHK("second kept", 1'b1, rx_store_o)
        set_efr(8'h0b);
        rx(ST2);
        `CHK("either stop", 1'b1, stop_det_o)
        set_efr(8'h07);
        rx(RS1);
        `CHK("either resume", 1'b1, resume_det_o)
        set_efr(8'h0f);
        rx(ST1);
        `CHK("half pair", 1'b0, stop_det_o)
        i_peer.send(ST1);
        i_peer.send(ST2);
        i_peer.rest();
        `CHK("pair stop", 1'b1, stop_det_o)
        set_efr(8'h03);
        i_peer.send(RS1);
        i_peer.send(RS2);
        i_peer.rest();
        `CHK("pair resume", 1'b1, resume_det_o)
        done("receive");
        give_verdict();
    end
endmodule
`default_nettype wire
